// ===== pkg/acr_consts.svh
// Constants for the converter control and result block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH
// Register indices; byte address is four times the index
`define ACR_IDX_RES_LO   8'h78
`define ACR_IDX_RES_HI   8'h79
`define ACR_IDX_CTRL_A   8'h7A
`define ACR_IDX_CTRL_B   8'h7B
`define ACR_IDX_CHREF    8'h7C
`define ACR_IDX_DIS_LO   8'h7E
`define ACR_IDX_DIS_HI   8'h7F
`define ACR_IDX_MISC     8'h77
// Control A fields
`define ACR_A_ON         7
`define ACR_A_GO         6
`define ACR_A_AUTO       5
`define ACR_A_FLAG       4
`define ACR_A_IE         3
// Control B and misc fields
`define ACR_B_BIPOLAR    7
`define ACR_M_EXT_IN     2
`define ACR_M_INT_OUT    1
// Masks of writable bits
`define ACR_B_MASK       8'h87
`define ACR_DHI_MASK     8'h70
`define ACR_MISC_MASK    8'h06
// Reset values
`define ACR_RST_BYTE     8'h00
`define ACR_RST_RES      10'h000
// Conversion lengths in converter clocks
`define ACR_LEN_FIRST    5'd25
`define ACR_LEN_NORM     5'd13
// Unipolar saturation value
`define ACR_SAT_VAL      10'h3FF
// Bus responses
`define ACR_RESP_OKAY    2'h0
`define ACR_RESP_SLVERR  2'h2
`endif

// ===== pkg/acr_pkg.sv
// Types for the converter control and result block.
// Assumes the constants header is on the include path.
package acr_pkg;
  // Conversion sequencer states
  typedef enum logic {ACR_IDLE, ACR_CONV} acr_state_t;
  // Trigger source codes
  typedef enum logic [2:0] {
    ACR_TS_FREE, ACR_TS_COMP, ACR_TS_EXT0, ACR_TS_T1_CMPA,
    ACR_TS_T1_OVF, ACR_TS_T1_CMPB, ACR_TS_T1_CAPT, ACR_TS_WDOG
  } acr_trig_t;
  // One register byte
  typedef logic [7:0] acr_byte_t;
endpackage

// ===== rtl/acr_prescaler.sv
// Converter clock prescaler: one-cycle tick every N system clocks.
// Assumes run drops whenever the converter is off.
`timescale 1ns/1ps
`include "acr_consts.svh"
module acr_prescaler
  import acr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] code,
  output logic            tick
);
  logic [6:0] cnt_q;  // Divider count
  logic [6:0] cnt_d;  // Next count
  logic [6:0] last;   // Terminal count

  // Division factor minus one; codes 0 and 1 both give two
  function automatic logic [6:0] div_last(input logic [2:0] c);
    logic [7:0] f;
    f = (c <= 3'h1) ? 8'h02 : (8'h01 << c);
    return 7'(f - 8'h01);
  endfunction

  // Terminal count and next count
  always_comb begin
    last  = div_last(code);
    tick  = run && (cnt_q >= last);
    cnt_d = (!run || tick) ? 7'h00 : 7'(cnt_q + 7'h01);
  end

  // Count register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ===== rtl/acr_top.sv
// Converter control, prescaler, trigger and result logic behind AXI4-Lite.
// Assumes an analog core sampling CORE_RESULT when a conversion ends.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "acr_consts.svh"
module acr_top
  import acr_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        GLOBAL_IRQ_ON,
  input  wire logic        IRQ_ACK,
  output logic             IRQ_REQ,
  input  wire logic [6:0]  TRIG_FLAGS,
  input  wire logic [9:0]  CORE_RESULT,
  input  wire logic        CORE_POS_NOT_ABOVE,
  output logic             CORE_ON,
  output logic             CORE_BUSY,
  output logic             CORE_INIT,
  output logic             CORE_CLK_TICK,
  output logic [4:0]       CORE_CHANNEL,
  output logic [1:0]       CORE_REF_SEL,
  output logic             CORE_BIPOLAR,
  output logic             REF_FROM_EXT,
  output logic             REF_OUT_DRIVE,
  input  wire logic [10:0] PIN_RAW,
  output logic [10:0]      PIN_READ,
  output logic [10:0]      PIN_BUF_OFF
);
  // Register file
  acr_byte_t  ctla_q, ctla_d;     // Control A minus go and flag
  acr_byte_t  ctlb_q, ctlb_d;     // Control B
  acr_byte_t  chref_q, chref_d;   // Pending channel and reference select
  acr_byte_t  cur_q, cur_d;       // Channel and reference applied to core
  acr_byte_t  dlo_q, dlo_d;       // Input disable low
  acr_byte_t  dhi_q, dhi_d;       // Input disable high
  acr_byte_t  misc_q, misc_d;     // Misc analog control
  logic [9:0] res_q, res_d;       // Stored result
  logic       flag_q, flag_d;     // Conversion done flag
  logic       lock_q, lock_d;     // Result lock after low byte read
  logic       first_q, first_d;   // Next conversion is the first
  logic       refchg_q, refchg_d; // Reference changed since last start
  logic       long_q, long_d;     // Current conversion is long
  logic [4:0] cnt_q, cnt_d;       // Converter clocks in this conversion
  acr_state_t st_q, st_d;         // Sequencer state
  logic       trig_prev_q;        // Trigger level last cycle
  logic [10:0] pin_q;             // Masked pin inputs
  // Bus slave
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [9:0]  awa_q, awa_d;
  logic [7:0]  wd_q, wd_d;
  logic        ws_q, ws_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdat_q, rdat_d;
  // Combinational helpers
  logic        tick, wr_go, rd_go, trig_lvl, trig_start, sw_start, start;
  logic        done, on_next, wr_ok, rd_ok;
  logic [15:0] view;
  logic [7:0]  rbyte;
  logic [9:0]  conv_val;

  // Register index hit test, used by both bus paths
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a == {2'h0, idx};
  endfunction

  // Converter clock source
  acr_prescaler u_presc (
    .clk  (MCLK),
    .rst  (SRST),
    .run  (ctla_q[`ACR_A_ON]),
    .code (ctla_q[2:0]),
    .tick (tick)
  );

  // Bus handshakes
  assign S_AXI_AWREADY = !aw_q && !b_q;
  assign S_AXI_WREADY  = !w_q && !b_q;
  assign S_AXI_ARREADY = !r_q;
  assign wr_go = aw_q && w_q;
  assign rd_go = S_AXI_ARVALID && !r_q;

  // Result layout follows the justify bit live
  always_comb begin
    view = chref_q[5] ? {res_q, 6'h00} : {6'h00, res_q};
  end

  // Read mux
  always_comb begin
    rd_ok = 1'b1;
    rbyte = 8'h00;
    if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_RES_LO)) begin
      rbyte = view[7:0];
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_RES_HI)) begin
      rbyte = view[15:8];
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_CTRL_A)) begin
      rbyte = {ctla_q[7], st_q == ACR_CONV, ctla_q[5], flag_q, ctla_q[3:0]};
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_CTRL_B)) begin
      rbyte = ctlb_q;
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_CHREF)) begin
      rbyte = chref_q;
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_DIS_LO)) begin
      rbyte = dlo_q;
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_DIS_HI)) begin
      rbyte = dhi_q;
    end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_MISC)) begin
      rbyte = misc_q;
    end else begin
      rd_ok = 1'b0;  // Unmapped
    end
  end

  // Trigger selection and edge detection
  always_comb begin
    trig_lvl = (ctlb_q[2:0] == ACR_TS_FREE) ? 1'b0 : TRIG_FLAGS[3'(ctlb_q[2:0] - 3'h1)];
    trig_start = ctla_q[`ACR_A_AUTO] && ctla_q[`ACR_A_ON]
                 && trig_lvl && !trig_prev_q;
  end

  // Conversion value from core
  always_comb begin
    conv_val = CORE_RESULT;
    if (!ctlb_q[`ACR_B_BIPOLAR] && CORE_POS_NOT_ABOVE) begin
      conv_val = `ACR_SAT_VAL;
    end
  end

  // Next state of bus slave and register file
  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
    awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
    bresp_d = bresp_q; rresp_d = rresp_q; rdat_d = rdat_q;
    ctla_d = ctla_q; ctlb_d = ctlb_q; chref_d = chref_q; cur_d = cur_q;
    dlo_d = dlo_q; dhi_d = dhi_q; misc_d = misc_q;
    res_d = res_q; flag_d = flag_q; lock_d = lock_q; first_d = first_q;
    refchg_d = refchg_q; long_d = long_q; cnt_d = cnt_q; st_d = st_q;
    wr_ok = 1'b1;
    sw_start = 1'b0;
    // Address and data capture, either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_d = 1'b1;
      awa_d = S_AXI_AWADDR[11:2];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_d = 1'b1;
      wd_d = S_AXI_WDATA[7:0];
      ws_d = S_AXI_WSTRB[0];
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      b_d = 1'b0;
    end
    // Register write once both halves are held
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      if (!ws_q) begin
        wr_ok = 1'b1;  // Lane 0 not strobed: no effect
      end else if (hit(awa_q, `ACR_IDX_CTRL_A)) begin
        ctla_d = {wd_q[7], 1'b0, wd_q[5], 1'b0, wd_q[3:0]};
        if (!ctla_q[`ACR_A_ON] && wd_q[`ACR_A_ON]) begin
          first_d = 1'b1;
        end
        sw_start = wd_q[`ACR_A_GO] && wd_q[`ACR_A_ON];
        if (wd_q[`ACR_A_FLAG]) begin
          flag_d = 1'b0;
        end
      end else if (hit(awa_q, `ACR_IDX_CTRL_B)) begin
        ctlb_d = wd_q & `ACR_B_MASK;
      end else if (hit(awa_q, `ACR_IDX_CHREF)) begin
        chref_d = wd_q;
        if (wd_q[7:6] != chref_q[7:6]) begin
          refchg_d = 1'b1;
        end
      end else if (hit(awa_q, `ACR_IDX_DIS_LO)) begin
        dlo_d = wd_q;
      end else if (hit(awa_q, `ACR_IDX_DIS_HI)) begin
        dhi_d = wd_q & `ACR_DHI_MASK;
      end else if (hit(awa_q, `ACR_IDX_MISC)) begin
        misc_d = wd_q & `ACR_MISC_MASK;
        if (wd_q[`ACR_M_EXT_IN] != misc_q[`ACR_M_EXT_IN]) begin
          refchg_d = 1'b1;
        end
      end else if (!hit(awa_q, `ACR_IDX_RES_LO) && !hit(awa_q, `ACR_IDX_RES_HI)) begin
        wr_ok = 1'b0;
      end
      bresp_d = wr_ok ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
    end
    // Register read with its lock side effect
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      r_d = 1'b0;
    end
    if (rd_go) begin
      r_d = 1'b1;
      rdat_d = {24'h000000, rbyte};
      rresp_d = rd_ok ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
      if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_RES_LO)) begin
        lock_d = 1'b1;
      end else if (hit(S_AXI_ARADDR[11:2], `ACR_IDX_RES_HI)) begin
        lock_d = 1'b0;
      end
    end
    // Conversion sequencer
    on_next = ctla_d[`ACR_A_ON];
    done = (st_q == ACR_CONV) && tick && (cnt_q == 5'(long_q ? `ACR_LEN_FIRST - 5'd1
                                                          : `ACR_LEN_NORM - 5'd1));
    start = 1'b0;
    if (st_q == ACR_CONV && tick) begin
      cnt_d = 5'(cnt_q + 5'd1);
    end
    if (done) begin
      st_d = ACR_IDLE;
      flag_d = 1'b1;
      if (!lock_q) begin
        res_d = conv_val;
      end
      start = ctla_q[`ACR_A_AUTO] && (ctlb_q[2:0] == ACR_TS_FREE);
    end
    if (st_q == ACR_IDLE || done) begin
      start = start || sw_start || trig_start;
    end
    if (IRQ_ACK && !done) begin
      flag_d = 1'b0;
    end
    if (start && on_next) begin
      st_d = ACR_CONV;
      cnt_d = 5'd0;
      long_d = first_d || refchg_d;
      first_d = 1'b0;
      refchg_d = 1'b0;
    end
    if (!on_next) begin
      st_d = ACR_IDLE;
    end
    // Core selection only moves between conversions
    cur_d = (st_q == ACR_CONV && !done) ? cur_q : chref_d;
  end

  // Register all state
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 10'h000; wd_q <= 8'h00; ws_q <= 1'b0;
      bresp_q <= `ACR_RESP_OKAY; rresp_q <= `ACR_RESP_OKAY; rdat_q <= 32'h00000000;
      ctla_q <= `ACR_RST_BYTE; ctlb_q <= `ACR_RST_BYTE; chref_q <= `ACR_RST_BYTE;
      cur_q <= `ACR_RST_BYTE; dlo_q <= `ACR_RST_BYTE; dhi_q <= `ACR_RST_BYTE;
      misc_q <= `ACR_RST_BYTE; res_q <= `ACR_RST_RES;
      flag_q <= 1'b0; lock_q <= 1'b0; first_q <= 1'b0; refchg_q <= 1'b0;
      long_q <= 1'b0; cnt_q <= 5'd0; st_q <= ACR_IDLE;
      trig_prev_q <= 1'b0; pin_q <= 11'h000;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
      bresp_q <= bresp_d; rresp_q <= rresp_d; rdat_q <= rdat_d;
      ctla_q <= ctla_d; ctlb_q <= ctlb_d; chref_q <= chref_d;
      cur_q <= cur_d; dlo_q <= dlo_d; dhi_q <= dhi_d;
      misc_q <= misc_d; res_q <= res_d;
      flag_q <= flag_d; lock_q <= lock_d; first_q <= first_d; refchg_q <= refchg_d;
      long_q <= long_d; cnt_q <= cnt_d; st_q <= st_d;
      trig_prev_q <= trig_lvl;
      pin_q <= PIN_RAW & ~{dhi_q[6:4], dlo_q};
    end
  end

  // Outputs
  assign S_AXI_BVALID  = b_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = r_q;
  assign S_AXI_RDATA   = rdat_q;
  assign S_AXI_RRESP   = rresp_q;
  assign IRQ_REQ       = flag_q && ctla_q[`ACR_A_IE] && GLOBAL_IRQ_ON;
  assign CORE_ON       = ctla_q[`ACR_A_ON];
  assign CORE_BUSY     = st_q == ACR_CONV;
  assign CORE_INIT     = long_q && (st_q == ACR_CONV);
  assign CORE_CLK_TICK = tick;
  assign CORE_CHANNEL  = cur_q[4:0];
  assign CORE_REF_SEL  = cur_q[7:6];
  assign CORE_BIPOLAR  = ctlb_q[`ACR_B_BIPOLAR];
  assign REF_FROM_EXT  = misc_q[`ACR_M_EXT_IN];
  assign REF_OUT_DRIVE = misc_q[`ACR_M_INT_OUT];
  assign PIN_READ      = pin_q;
  assign PIN_BUF_OFF   = {dhi_q[6:4], dlo_q};

  // Checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  sequence s_ctla_write;
    wr_go && ws_q && hit(awa_q, `ACR_IDX_CTRL_A);
  endsequence
  a_off_aborts: assert property (!ctla_q[`ACR_A_ON] |-> st_q == ACR_IDLE)
    else $error("converter off but conversion running");
  a_zero_go_kept: assert property ((s_ctla_write and (!wd_q[`ACR_A_GO]
    && wd_q[`ACR_A_ON] && st_q == ACR_CONV && !done)) |=> st_q == ACR_CONV)
    else $error("zero write to start bit disturbed conversion");
  // Count never runs past the last clock of the conversion length
  a_conv_length: assert property (st_q == ACR_CONV |-> cnt_q <= (long_q ? 5'd24 : 5'd12))
    else $error("conversion length wrong");
  a_flag_on_done: assert property (done |=> flag_q)
    else $error("flag not set at completion");
  a_ack_clears: assert property (IRQ_ACK && !done |=> !flag_q)
    else $error("vector acknowledge did not clear flag");
  a_irq_gate: assert property (IRQ_REQ == (flag_q && ctla_q[3] && GLOBAL_IRQ_ON))
    else $error("interrupt request mismatch");
  a_lock_holds: assert property (lock_q && done |=> $stable(res_q))
    else $error("locked result was overwritten");
  a_free_no_trig: assert property (ctlb_q[2:0] == 3'h0 |-> !trig_start)
    else $error("free running selection triggered");
  a_auto_off_quiet: assert property (!ctla_q[`ACR_A_AUTO] |-> !trig_start)
    else $error("trigger while auto off");
  // Selection may only move on the edge after a completion or outside conversions
  a_sel_held: assert property (st_q == ACR_CONV && !$past(done)
    && $past(st_q) == ACR_CONV |-> $stable(cur_q))
    else $error("selection changed mid conversion");
endmodule

// ===== bench/acr_core_model.sv
// Behavioural model of the analog core beside the converter block.
// Assumes busy stays high for the whole of every conversion.
`timescale 1ns/1ps
module acr_core_model (
  input  wire logic       clk,
  input  wire logic       busy,
  input  wire logic [9:0] value,
  input  wire logic       pna_in,
  output logic [9:0]      result,
  output logic            pos_not_above
);
  // Last shown value, inverted every idle cycle so stale data matches only on alternate idle cycles
  logic [9:0] last_q = 10'h155;
  always @(posedge clk) begin
    if (busy) last_q <= value;
    else last_q <= ~last_q;
  end
  // Real sample only while a conversion runs
  assign result        = busy ? value : last_q;
  assign pos_not_above = busy ? pna_in : ~pna_in;
endmodule

// ===== bench/tb.sv
// Self-checking bench for the converter control block over AXI4-Lite.
// Assumes the design, the package and the core model are compiled first.
`timescale 1ns/1ps
`include "acr_consts.svh"
module tb;
  import acr_pkg::*;
  logic        mclk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rd_r, rsel, wr_r;
  logic        gie, ack, irq, pna_set, pna, on, busy, init, tick, bip, rext, rout;
  logic [6:0]  trig;
  logic [9:0]  value, old, result;
  logic [4:0]  chan;
  logic [10:0] praw, pread, poff, dis;
  logic [15:0] pair;
  int          n_mismatch, n_compared, tcount, ticks, started, c, n;
  acr_core_model core (.clk(mclk), .busy(busy), .value(value), .pna_in(pna_set),
    .result(result), .pos_not_above(pna));
  acr_top dut (.MCLK(mclk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .GLOBAL_IRQ_ON(gie), .IRQ_ACK(ack), .IRQ_REQ(irq), .TRIG_FLAGS(trig),
    .CORE_RESULT(result), .CORE_POS_NOT_ABOVE(pna), .CORE_ON(on), .CORE_BUSY(busy),
    .CORE_INIT(init), .CORE_CLK_TICK(tick), .CORE_CHANNEL(chan), .CORE_REF_SEL(rsel),
    .CORE_BIPOLAR(bip), .REF_FROM_EXT(rext), .REF_OUT_DRIVE(rout), .PIN_RAW(praw),
    .PIN_READ(pread), .PIN_BUF_OFF(poff));
  // System clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Ticks seen while converting
  always @(posedge mclk) if (busy === 1'b1 && tick === 1'b1) tcount <= tcount + 1;
  // Expected division factor of a divider code
  function automatic int div_of(input int code);
    return (code < 2) ? 2 : (1 << code);
  endfunction
  // Expected register pair for a stored result
  function automatic logic [15:0] just(input logic l, input logic [9:0] r);
    return l ? {r, 6'h00} : {6'h00, r};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One AXI write; address and data released each at its own handshake
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    int k;
    awaddr  <= {2'b00, i, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        wr_r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (k == 100) chk("write answer", 1, 0);
    @(posedge mclk);
  endtask
  // One AXI read into rd_v and rd_r
  task automatic rd(input logic [7:0] i);
    int k;
    araddr  <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge mclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    if (k == 100) chk("read answer", 1, 0);
    @(posedge mclk);
  endtask
  // Low byte first, then high byte
  task automatic rpair();
    rd(`ACR_IDX_RES_LO);
    pair[7:0] = rd_v[7:0];
    rd(`ACR_IDX_RES_HI);
    pair[15:8] = rd_v[7:0];
  endtask
  // Waits for a conversion to start and finish
  task automatic conv();
    int k;
    for (k = 0; k < 400 && busy !== 1'b1; k++) @(posedge mclk);
    started = (busy === 1'b1);
    for (k = 0; k < 20000 && busy === 1'b1; k++) @(posedge mclk);
    @(posedge mclk);
    ticks = tcount;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    {gie, ack, pna_set, trig, value, praw, tcount} = '0;
    void'($urandom(32'hB5A76EA3));
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    // Reset values and an unmapped place
    for (c = 0; c < 9; c++) begin
      rd(8'(8'h77 + c));
      chk("reset value", 0, rd_v);
    end
    rd(8'h00);
    chk("unmapped resp", `ACR_RESP_SLVERR, rd_r);
    wr(8'h00, 8'h5A);
    chk("unmapped wresp", `ACR_RESP_SLVERR, wr_r);
    $display("test reset done");
    // Every divider code
    for (c = 0; c < 8; c++) begin
      wr(`ACR_IDX_CTRL_A, 8'h80 | c);
      gap(n);
      gap(n);
      chk("tick spacing", div_of(c), n);
    end
    chk("write resp", `ACR_RESP_OKAY, wr_r);
    $display("test prescaler done");
    // First conversion, flag, layouts
    value <= $urandom;
    tcount = 0;
    wr(`ACR_IDX_CTRL_A, 8'hC0);
    chk("init", 1, init);
    rd(`ACR_IDX_CTRL_A);
    chk("go busy", 1, rd_v[6]);
    conv();
    chk("first length", 25, ticks);
    rd(`ACR_IDX_CTRL_A);
    chk("ctrl after", 8'h90, rd_v);
    rpair();
    chk("right pair", just(0, value), pair);
    wr(`ACR_IDX_CHREF, 8'h20);
    rpair();
    chk("left pair", just(1, value), pair);
    wr(`ACR_IDX_CTRL_A, 8'h90);
    rd(`ACR_IDX_CTRL_A);
    chk("flag cleared", 8'h80, rd_v);
    $display("test first done");
    // Lock, later length, zero write to go
    old = value;
    rd(`ACR_IDX_RES_LO);
    value <= ~old;
    tcount = 0;
    wr(`ACR_IDX_CTRL_A, 8'hC0);
    wr(`ACR_IDX_CTRL_A, 8'h80);
    chk("go kept", 1, busy);
    conv();
    chk("later length", 13, ticks);
    rd(`ACR_IDX_RES_HI);
    chk("locked high", old[9:2], rd_v);
    $display("test lock done");
    // Interrupt request and vector clear
    wr(`ACR_IDX_CTRL_A, 8'h88);
    chk("irq masked", 0, irq);
    gie <= 1'b1;
    @(posedge mclk);
    chk("irq on", 1, irq);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    @(posedge mclk);
    chk("irq acked", 0, irq);
    $display("test irq done");
    // Unipolar saturation and bipolar pass
    wr(`ACR_IDX_CHREF, 8'h00);
    pna_set <= 1'b1;
    for (c = 0; c < 2; c++) begin
      wr(`ACR_IDX_CTRL_B, c << 7);
      value <= $urandom;
      wr(`ACR_IDX_CTRL_A, 8'hC0);
      conv();
      rpair();
      chk("gain result", c ? value : `ACR_SAT_VAL, pair);
      chk("bipolar out", c, bip);
    end
    pna_set <= 1'b0;
    $display("test gain done");
    // Each trigger source, with a stray edge on another
    wr(`ACR_IDX_CTRL_A, 8'hA0);
    for (c = 1; c < 8; c++) begin
      wr(`ACR_IDX_CTRL_B, c);
      trig <= 7'h01 << (c % 7);
      repeat (4) @(posedge mclk);
      chk("stray edge", 0, busy);
      trig <= 7'h01 << (c - 1);
      conv();
      chk("source start", 1, started);
      trig <= 7'h00;
    end
    trig <= 7'h02;
    wr(`ACR_IDX_CTRL_B, 8'h01);
    wr(`ACR_IDX_CTRL_B, 8'h02);
    conv();
    chk("switch edge", 1, started);
    trig <= 7'h00;
    wr(`ACR_IDX_CTRL_B, 8'h00);
    repeat (8) @(posedge mclk);
    chk("free select", 0, busy);
    $display("test trigger done");
    // Free running restarts, then disable aborts
    // Busy never drops while free running, so count converter clocks instead
    tcount = 0;
    wr(`ACR_IDX_CTRL_A, 8'hE0);
    for (c = 0; c < 400 && tcount < 40; c++) @(posedge mclk);
    chk("free restart", 1, busy);
    chk("free ticks", 1, tcount >= 40);
    wr(`ACR_IDX_CTRL_A, 8'h00);
    chk("abort busy", 0, busy);
    chk("abort on", 0, on);
    rd(`ACR_IDX_CTRL_A);
    chk("abort ctrl", 8'h10, rd_v);
    $display("test free done");
    // Selection waits for completion; reference change lengthens next
    wr(`ACR_IDX_CTRL_A, 8'hC0);
    conv();
    wr(`ACR_IDX_CTRL_A, 8'hC0);
    wr(`ACR_IDX_CHREF, 8'h4A);
    chk("channel held", 0, chan);
    conv();
    chk("channel after", 5'h0A, chan);
    chk("ref after", 2'h1, rsel);
    tcount = 0;
    wr(`ACR_IDX_CTRL_A, 8'hC0);
    conv();
    chk("ref length", 25, ticks);
    $display("test select done");
    // Input disables and reference enables
    dis = $urandom;
    praw <= $urandom;
    wr(`ACR_IDX_DIS_LO, dis[7:0]);
    wr(`ACR_IDX_DIS_HI, {1'b0, dis[10:8], 4'h0});
    wr(`ACR_IDX_MISC, 8'h06);
    repeat (2) @(posedge mclk);
    chk("pin read", praw & ~dis, pread);
    chk("buf off", dis, poff);
    chk("ext ref", 1, rext);
    chk("ref out", 1, rout);
    $display("test pins done");
    print_verdict();
  end
  // Edges from one tick to the next
  task automatic gap(output int g);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge mclk);
      if (tick === 1'b1) break;
    end
    for (g = 1; g < 300; g++) begin
      @(posedge mclk);
      if (tick === 1'b1) break;
    end
  endtask
endmodule
